// file: rtl/alarm_consts.vh
// Register offsets, field positions and encodings of the dual alarm block.
// Assumes inclusion by bare name from the alarm design files.
`ifndef ALARM_CONSTS_VH
`define ALARM_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define ADDR_THRESH_ONE   6'h20
`define ADDR_THRESH_TWO   6'h22
`define ADDR_COUNT_ONE    6'h24
`define ADDR_COUNT_TWO    6'h26
`define ADDR_CONTROL      6'h28
`define ADDR_STATUS       6'h3C

// ----------------------------------------------------------------------------
// Reset values and read masks
// ----------------------------------------------------------------------------
`define RESET_WORD        16'h0000
`define THRESH_MASK       16'hBFFF
`define COUNT_MASK        16'h00FF
`define CONTROL_MASK      16'hFF17
`define STATUS_MASK       16'h0300

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define THRESH_DIR_BIT    15
`define THRESH_MAG_HI     13
`define CTL_ROC_TWO_BIT   15
`define CTL_SRC_TWO_HI    14
`define CTL_SRC_TWO_LO    12
`define CTL_ROC_ONE_BIT   11
`define CTL_SRC_ONE_HI    10
`define CTL_SRC_ONE_LO    8
`define CTL_FILT_BIT      4
`define CTL_OUT_EN_BIT    2
`define CTL_OUT_POL_BIT   1
`define CTL_OUT_SEL_BIT   0
`define STAT_ALARM_TWO    9
`define STAT_ALARM_ONE    8

// ----------------------------------------------------------------------------
// Source selection codes
// ----------------------------------------------------------------------------
`define SRC_OFF           3'h0
`define SRC_SUPPLY        3'h1
`define SRC_RATE          3'h2
`define SRC_AUX           3'h5
`define SRC_TEMP          3'h6

`endif

// file: rtl/alarm_channel.v
// One alarm channel: static or rate-of-change comparison against a threshold.
// Assumes sample_i pulses once per output data update on the same clock.
`include "alarm_consts.vh"
module alarm_channel #(
    parameter DATA_W  = 14,
    parameter COUNT_W = 8
) (
    // Clock and reset
    input  wire               sys_clk_i,
    input  wire               rstn_i,
    // Configuration
    input  wire               active_i,
    input  wire               roc_i,
    input  wire               signed_i,
    input  wire [15:0]        thresh_i,
    input  wire [COUNT_W-1:0] count_i,
    // Source data
    input  wire               sample_i,
    input  wire [DATA_W-1:0]  data_i,
    // Result
    output reg                event_o
);

    localparam ACC_W = DATA_W + 2 + COUNT_W;

    reg  signed [DATA_W+1:0]  prev_reg;
    reg                       have_prev_reg;
    reg  signed [ACC_W-1:0]   acc_reg;
    reg         [COUNT_W-1:0] seen_reg;

    // Widen a source word to signed, respecting the source's own format.
    function signed [DATA_W+1:0] widen;
        input [DATA_W-1:0] v;
        input              s;
        begin
            widen = s ? {{2{v[DATA_W-1]}}, v} : {2'b00, v};
        end
    endfunction

    wire signed [DATA_W+1:0]  cur      = widen(data_i, signed_i);
    wire signed [DATA_W+1:0]  thr      = widen(thresh_i[`THRESH_MAG_HI:0], signed_i | roc_i);        // [RULE3]
    wire                      greater  = thresh_i[`THRESH_DIR_BIT];                                   // [RULE4]
    wire signed [DATA_W+1:0]  delta    = cur - prev_reg;                                              // [RULE6]
    wire signed [ACC_W-1:0]   acc_new  = acc_reg + {{COUNT_W{delta[DATA_W+1]}}, delta};
    wire        [COUNT_W-1:0] n_eff    = (count_i == {COUNT_W{1'b0}}) ? {{(COUNT_W-1){1'b0}}, 1'b1} : count_i;
    wire        [COUNT_W-1:0] seen_new = seen_reg + {{(COUNT_W-1){1'b0}}, 1'b1};
    // Comparing the sum with threshold times count avoids a divider.
    wire signed [ACC_W-1:0]   thr_n    = thr * $signed({1'b0, n_eff});                                // [RULE7]

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prev_reg      <= {(DATA_W+2){1'b0}};
            have_prev_reg <= 1'b0;
            acc_reg       <= {ACC_W{1'b0}};
            seen_reg      <= {COUNT_W{1'b0}};
            event_o       <= 1'b0;
        end else begin
            event_o <= 1'b0;
            if (!active_i || !roc_i) begin
                have_prev_reg <= 1'b0;
                acc_reg       <= {ACC_W{1'b0}};
                seen_reg      <= {COUNT_W{1'b0}};
            end
            if (active_i && sample_i) begin                                                         // [RULE17]
                if (!roc_i) begin
                    event_o <= greater ? (cur > thr) : (cur < thr);                                 // [RULE2]
                end else begin
                    prev_reg      <= cur;
                    have_prev_reg <= 1'b1;
                    if (have_prev_reg) begin
                        if (seen_new >= n_eff) begin                                                // [RULE5]
                            event_o  <= greater ? (acc_new > thr_n) : (acc_new < thr_n);            // [RULE7]
                            acc_reg  <= {ACC_W{1'b0}};
                            seen_reg <= {COUNT_W{1'b0}};
                        end else begin
                            acc_reg  <= acc_new;
                            seen_reg <= seen_new;
                        end
                    end
                end
            end
        end
    end

endmodule

// file: rtl/line_router.v
// Drives the two general-purpose lines from the competing functions.
// Assumes all inputs are levels on the same clock as this module.
module line_router (
    // Clock and reset
    input  wire       sys_clk_i,
    input  wire       rstn_i,
    // General-purpose line control
    input  wire [1:0] gpio_out_en_i,
    input  wire [1:0] gpio_level_i,
    // Data-ready routing
    input  wire       drdy_en_i,
    input  wire       drdy_pol_i,
    input  wire       drdy_sel_i,
    input  wire       drdy_i,
    // Alarm routing
    input  wire       alarm_en_i,
    input  wire       alarm_pol_i,
    input  wire       alarm_sel_i,
    input  wire       alarm_i,
    // Lines
    output reg  [1:0] line_o,
    output reg  [1:0] line_oe_o
);

    integer k;

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            line_o    <= 2'h0;
            line_oe_o <= 2'h0;
        end else begin
            for (k = 0; k < 2; k = k + 1) begin
                if (gpio_out_en_i[k]) begin                                          // [RULE16]
                    line_o[k]    <= gpio_level_i[k];
                    line_oe_o[k] <= 1'b1;
                end else if (drdy_en_i && (drdy_sel_i == k[0])) begin                // [RULE16]
                    line_o[k]    <= ~(drdy_i ^ drdy_pol_i);
                    line_oe_o[k] <= 1'b1;
                end else if (alarm_en_i && (alarm_sel_i == k[0])) begin              // [RULE13] [RULE14]
                    line_o[k]    <= ~(alarm_i ^ alarm_pol_i);
                    line_oe_o[k] <= 1'b1;
                end else begin
                    line_o[k]    <= 1'b0;
                    line_oe_o[k] <= 1'b0;
                end
            end
        end
    end

endmodule

// file: rtl/alarm_block.v
// Dual alarm event detector with its register file and line routing.
// Assumes the serial interface engine issues word-wide register strobes on sys_clk_i.
//
// Function
// RULE1: Two independent alarm channels, each with own threshold, count, mode, source.
// RULE2: A channel flags an event when its selected data meets the comparison.
// RULE3: Threshold magnitude sits in bits 13:0 in source format; bit 14 unused. In rate mode the code sign-extends it for all sources.
// RULE4: Threshold bit 15 set means greater-than, clear means less-than.
// RULE5: Sample-count bits 7:0 set how many deltas are averaged; 15:8 unused.
// RULE6: Rate mode forms a delta by subtracting the previous sample from each new one.
// RULE7: Sum of the deltas divided by count is compared with the threshold.
// RULE8: Control bit 15 puts the second alarm in rate-of-change mode.
// RULE9: Control bit 11 puts the first alarm in rate-of-change mode.
// RULE10: Control bits 14:12 pick the second source; 000 and unlisted codes inactive.
// RULE11: Control bits 10:8 pick the first source with the same encoding.
// RULE12: Control bit 4 selects filtered data when set, unfiltered when clear.
// RULE13: Control bit 2 enables the alarm line; bit 1 sets its polarity.
// RULE14: Control bit 0 routes the alarm to line one when set, line zero when clear.
// RULE15: Status bits 9 and 8 hold alarm two and one until a status read.
// RULE16: Line control beats data-ready routing, which beats alarm routing.
// RULE17: Comparisons run once per new sample; unused bits read as zero.
module alarm_block #(
    parameter DATA_W  = 14,
    parameter COUNT_W = 8
) (
    // Clock and reset
    input  wire              sys_clk_i,
    input  wire              rstn_i,
    // Register port
    input  wire              reg_wr_i,
    input  wire              reg_rd_i,
    input  wire [5:0]        reg_addr_i,
    input  wire [15:0]       reg_wdata_i,
    output reg  [15:0]       reg_rdata_o,
    // Source data
    input  wire              sample_i,
    input  wire [DATA_W-1:0] supply_raw_i,
    input  wire [DATA_W-1:0] supply_filt_i,
    input  wire [DATA_W-1:0] rate_raw_i,
    input  wire [DATA_W-1:0] rate_filt_i,
    input  wire [DATA_W-1:0] aux_raw_i,
    input  wire [DATA_W-1:0] aux_filt_i,
    input  wire [DATA_W-1:0] temp_raw_i,
    input  wire [DATA_W-1:0] temp_filt_i,
    // Competing line functions
    input  wire [1:0]        gpio_out_en_i,
    input  wire [1:0]        gpio_level_i,
    input  wire              drdy_en_i,
    input  wire              drdy_pol_i,
    input  wire              drdy_sel_i,
    input  wire              drdy_i,
    // General-purpose lines
    output wire [1:0]        line_o,
    output wire [1:0]        line_oe_o,
    // Alarm status
    output reg  [1:0]        alarm_flags_o
);

`include "alarm_consts.vh"

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    reg  [15:0] thresh_one_reg;
    reg  [15:0] thresh_two_reg;
    reg  [15:0] count_one_reg;
    reg  [15:0] count_two_reg;
    reg  [15:0] control_reg;
    reg  [15:0] rdata_next;

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            thresh_one_reg <= `RESET_WORD;
            thresh_two_reg <= `RESET_WORD;
            count_one_reg  <= `RESET_WORD;
            count_two_reg  <= `RESET_WORD;
            control_reg    <= `RESET_WORD;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `ADDR_THRESH_ONE: thresh_one_reg <= reg_wdata_i & `THRESH_MASK;   // [RULE3]
                `ADDR_THRESH_TWO: thresh_two_reg <= reg_wdata_i & `THRESH_MASK;   // [RULE3]
                `ADDR_COUNT_ONE:  count_one_reg  <= reg_wdata_i & `COUNT_MASK;    // [RULE5]
                `ADDR_COUNT_TWO:  count_two_reg  <= reg_wdata_i & `COUNT_MASK;    // [RULE5]
                `ADDR_CONTROL:    control_reg    <= reg_wdata_i & `CONTROL_MASK;  // [RULE17]
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------------------
    // Codes outside the four listed sources leave a channel idle.
    function src_valid;
        input [2:0] code;
        begin
            src_valid = (code == `SRC_SUPPLY) || (code == `SRC_RATE) ||
                        (code == `SRC_AUX)    || (code == `SRC_TEMP);
        end
    endfunction

    function [DATA_W-1:0] src_pick;
        input [2:0]        code;
        input              filt;
        begin
            case (code)
                `SRC_SUPPLY: src_pick = filt ? supply_filt_i : supply_raw_i;
                `SRC_RATE:   src_pick = filt ? rate_filt_i   : rate_raw_i;
                `SRC_AUX:    src_pick = filt ? aux_filt_i    : aux_raw_i;
                `SRC_TEMP:   src_pick = filt ? temp_filt_i   : temp_raw_i;
                default:     src_pick = {DATA_W{1'b0}};
            endcase
        end
    endfunction

    // Rate and temperature words are two's complement, the others are unsigned.
    function src_signed;
        input [2:0] code;
        begin
            src_signed = (code == `SRC_RATE) || (code == `SRC_TEMP);
        end
    endfunction

    wire [2:0]        src_one  = control_reg[`CTL_SRC_ONE_HI:`CTL_SRC_ONE_LO];
    wire [2:0]        src_two  = control_reg[`CTL_SRC_TWO_HI:`CTL_SRC_TWO_LO];
    wire              use_filt = control_reg[`CTL_FILT_BIT];                     // [RULE12]
    wire [DATA_W-1:0] data_one = src_pick(src_one, use_filt);                    // [RULE11] [RULE12]
    wire [DATA_W-1:0] data_two = src_pick(src_two, use_filt);                    // [RULE10] [RULE12]
    wire              event_one;
    wire              event_two;

    // ------------------------------------------------------------------------
    // Alarm channels
    // ------------------------------------------------------------------------
    alarm_channel #(
        .DATA_W  (DATA_W),
        .COUNT_W (COUNT_W)
    ) u_channel_one (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .active_i  (src_valid(src_one)),                                         // [RULE11] [RULE1]
        .roc_i     (control_reg[`CTL_ROC_ONE_BIT]),                              // [RULE9]
        .signed_i  (src_signed(src_one)),
        .thresh_i  (thresh_one_reg),
        .count_i   (count_one_reg[COUNT_W-1:0]),
        .sample_i  (sample_i),
        .data_i    (data_one),
        .event_o   (event_one)
    );

    alarm_channel #(
        .DATA_W  (DATA_W),
        .COUNT_W (COUNT_W)
    ) u_channel_two (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .active_i  (src_valid(src_two)),                                         // [RULE10] [RULE1]
        .roc_i     (control_reg[`CTL_ROC_TWO_BIT]),                              // [RULE8]
        .signed_i  (src_signed(src_two)),
        .thresh_i  (thresh_two_reg),
        .count_i   (count_two_reg[COUNT_W-1:0]),
        .sample_i  (sample_i),
        .data_i    (data_two),
        .event_o   (event_two)
    );

    // ------------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------------
    // A new event in the cycle of a status read survives the clear.
    wire status_rd = reg_rd_i && (reg_addr_i == `ADDR_STATUS);

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            alarm_flags_o <= 2'h0;
        end else begin
            alarm_flags_o[0] <= event_one | (alarm_flags_o[0] & ~status_rd);    // [RULE15]
            alarm_flags_o[1] <= event_two | (alarm_flags_o[1] & ~status_rd);    // [RULE15]
        end
    end

    // ------------------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------------------
    always @* begin
        case (reg_addr_i)
            `ADDR_THRESH_ONE: rdata_next = thresh_one_reg;
            `ADDR_THRESH_TWO: rdata_next = thresh_two_reg;
            `ADDR_COUNT_ONE:  rdata_next = count_one_reg;
            `ADDR_COUNT_TWO:  rdata_next = count_two_reg;
            `ADDR_CONTROL:    rdata_next = control_reg;
            `ADDR_STATUS:     rdata_next = {6'h00, alarm_flags_o, 8'h00} & `STATUS_MASK;  // [RULE17]
            default:          rdata_next = 16'h0000;
        endcase
    end

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= `RESET_WORD;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_next;
        end
    end

    // ------------------------------------------------------------------------
    // Line routing
    // ------------------------------------------------------------------------
    line_router u_router (
        .sys_clk_i     (sys_clk_i),
        .rstn_i        (rstn_i),
        .gpio_out_en_i (gpio_out_en_i),
        .gpio_level_i  (gpio_level_i),
        .drdy_en_i     (drdy_en_i),
        .drdy_pol_i    (drdy_pol_i),
        .drdy_sel_i    (drdy_sel_i),
        .drdy_i        (drdy_i),
        .alarm_en_i    (control_reg[`CTL_OUT_EN_BIT]),                           // [RULE13]
        .alarm_pol_i   (control_reg[`CTL_OUT_POL_BIT]),                          // [RULE13]
        .alarm_sel_i   (control_reg[`CTL_OUT_SEL_BIT]),                          // [RULE14]
        .alarm_i       (|alarm_flags_o),
        .line_o        (line_o),
        .line_oe_o     (line_oe_o)
    );

endmodule

// file: test/alarm_checker_assertions.sv
// Concurrent checks on the ports of the dual alarm block.
// Assumes one clock domain and the binding at the foot of this file.
`include "alarm_consts.vh"
module alarm_checker (
    // Clock and reset
    input wire logic        sys_clk_i,
    input wire logic        rstn_i,
    // Register port and sample strobe
    input wire logic        reg_rd_i,
    input wire logic [5:0]  reg_addr_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        sample_i,
    // Line functions
    input wire logic [1:0]  gpio_out_en_i,
    input wire logic [1:0]  gpio_level_i,
    input wire logic        drdy_en_i,
    input wire logic        drdy_pol_i,
    input wire logic        drdy_sel_i,
    input wire logic        drdy_i,
    input wire logic [1:0]  line_o,
    input wire logic [1:0]  line_oe_o,
    input wire logic [1:0]  alarm_flags_o
);
    timeunit 1ns;
    timeprecision 100ps;
    wire stat_rd;
    wire mapped;
    assign stat_rd = reg_rd_i && reg_addr_i == `ADDR_STATUS;
    assign mapped = reg_addr_i inside {`ADDR_THRESH_ONE, `ADDR_THRESH_TWO, `ADDR_COUNT_ONE,
                                       `ADDR_COUNT_TWO, `ADDR_CONTROL, `ADDR_STATUS};
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    a_status_read_data: assert property (
        stat_rd |=> reg_rdata_o == {6'h00, $past(alarm_flags_o), 8'h00}) else $error("status read data wrong");
    a_unmapped_zero: assert property (
        reg_rd_i && !mapped |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
    a_rdata_holds: assert property (
        !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved without a read");
    a_flags_sticky: assert property (
        !stat_rd |=> (alarm_flags_o & $past(alarm_flags_o)) == $past(alarm_flags_o)) else $error("flag dropped");
    a_flag_after_sample: assert property (
        (alarm_flags_o & ~$past(alarm_flags_o)) != 2'b00 |-> $past(sample_i, 2)) else $error("flag without sample");
    a_status_clears: assert property (
        stat_rd && !$past(sample_i) |=> alarm_flags_o == 2'b00) else $error("status read did not clear");
    a_gpio_line_wins: assert property (
        gpio_out_en_i[0] |=> line_oe_o[0] && line_o[0] == $past(gpio_level_i[0])) else $error("line control lost");
    a_ready_beats_alarm: assert property (
        !gpio_out_en_i[1] && drdy_en_i && drdy_sel_i |=> line_oe_o[1] && line_o[1] == ($past(drdy_i) ~^ $past(drdy_pol_i)))
        else $error("data-ready routing lost");
endmodule
bind alarm_block alarm_checker chk_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o), .sample_i(sample_i), .gpio_out_en_i(gpio_out_en_i),
    .gpio_level_i(gpio_level_i), .drdy_en_i(drdy_en_i), .drdy_pol_i(drdy_pol_i), .drdy_sel_i(drdy_sel_i),
    .drdy_i(drdy_i), .line_o(line_o), .line_oe_o(line_oe_o), .alarm_flags_o(alarm_flags_o));

// file: test/host_model.sv
// Host side of the register port: one word read or write per call.
// Assumes its task is entered 1 ns after a rising edge of sys_clk_i.
module host_model (
    // Clock
    input  wire logic        sys_clk_i,
    // Register port
    output logic             reg_wr_o,
    output logic             reg_rd_o,
    output logic [5:0]       reg_addr_o,
    output logic [15:0]      reg_wdata_o,
    input  wire logic [15:0] reg_rdata_i
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 6'h15;
        reg_wdata_o = 16'h5A5A;
    end
    // Released lines show the inverse so a stale address or word never looks valid.
    task automatic access(input logic wr, input logic [5:0] a, input logic [15:0] d, output logic [15:0] q);
        reg_wr_o = wr;
        reg_rd_o = !wr;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(posedge sys_clk_i);
        #1;
        q = reg_rdata_i;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
        @(posedge sys_clk_i);
        #1;
    endtask
endmodule

// file: test/tb.sv
// Self-checking bench for the dual alarm block.
// Assumes the host model drives the register port and this module the rest.
`include "alarm_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk_i = 0, rstn_i = 0, sample_i = 0;
    logic        drdy_en_i = 0, drdy_pol_i = 0, drdy_sel_i = 0, drdy_i = 0;
    logic [1:0]  gpio_out_en_i = 0, gpio_level_i = 0;
    logic [13:0] raw [4] = '{default: 14'h0000};
    logic [13:0] filt [4] = '{default: 14'h0000};
    wire         reg_wr, reg_rd;
    wire  [5:0]  reg_addr;
    wire  [15:0] reg_wdata, reg_rdata;
    wire  [1:0]  line_o, line_oe_o, alarm_flags_o;
    int          fails = 0, tests_run = 0, cyc = 0;
    logic [15:0] q, t;
    logic [5:0]  amap [6] = '{`ADDR_THRESH_ONE, `ADDR_THRESH_TWO, `ADDR_COUNT_ONE, `ADDR_COUNT_TWO,
                              `ADDR_CONTROL, `ADDR_STATUS};
    logic [15:0] mask [5] = '{`THRESH_MASK, `THRESH_MASK, `COUNT_MASK, `COUNT_MASK, `CONTROL_MASK};
    logic [2:0]  c;
    logic        f, ch, hit;
    initial forever #2.5 sys_clk_i = ~sys_clk_i;
    host_model host_u (.sys_clk_i(sys_clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));
    alarm_block dut_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .sample_i(sample_i),
        .supply_raw_i(raw[0]), .supply_filt_i(filt[0]), .rate_raw_i(raw[1]), .rate_filt_i(filt[1]),
        .aux_raw_i(raw[2]), .aux_filt_i(filt[2]), .temp_raw_i(raw[3]), .temp_filt_i(filt[3]),
        .gpio_out_en_i(gpio_out_en_i), .gpio_level_i(gpio_level_i), .drdy_en_i(drdy_en_i),
        .drdy_pol_i(drdy_pol_i), .drdy_sel_i(drdy_sel_i), .drdy_i(drdy_i), .line_o(line_o),
        .line_oe_o(line_oe_o), .alarm_flags_o(alarm_flags_o));
    // ------------------------------------------------------------------------
    // Shared tasks and expectations
    // ------------------------------------------------------------------------
    task automatic results;
        $display("counts: tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        host_u.access(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [5:0] a);
        host_u.access(1'b0, a, 16'h0000, q);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    // Sources are scrambled after each pulse, so only the sampled word may count.
    task automatic give_sample;
        sample_i = 1'b1;
        step(1);
        sample_i = 1'b0;
        for (int k = 0; k < 4; k++) begin
            raw[k] = ~raw[k];
            filt[k] = ~filt[k];
        end
    endtask
    function automatic logic f_hit(input logic [2:0] sc, input logic [13:0] v, input logic [15:0] th);
        if (!(sc inside {3'h1, 3'h2, 3'h5, 3'h6})) return 1'b0;
        return th[15] ? (v > th[13:0]) : (v < th[13:0]);
    endfunction
    function automatic int idx(input logic [2:0] sc);
        return (sc == 3'h1) ? 0 : (sc == 3'h2) ? 1 : (sc == 3'h5) ? 2 : 3;
    endfunction
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end
    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        void'($urandom(41319));
        repeat (16) @(posedge sys_clk_i);
        #1 rstn_i = 1'b1;
        step(1);
        for (int i = 0; i < 6; i++) begin
            rd(amap[i]);
            check("reset value", q, `RESET_WORD);
        end
        for (int i = 0; i < 5; i++) begin
            t = 16'($urandom);
            wr(amap[i], t);
            rd(amap[i]);
            check("readback", q, t & mask[i]);
        end
        wr(6'h2A, 16'hFFFF);
        rd(6'h2A);
        check("unmapped", q, 16'h0000);
        wr(`ADDR_STATUS, 16'hFFFF);
        rd(`ADDR_STATUS);
        check("status write", q, 16'h0000);
        for (int i = 0; i < 5; i++) wr(amap[i], 16'h0000);
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            c = i[2:0];
            ch = i[3];
            f = 1'($urandom);
            t = {1'($urandom), 15'h0800};
            for (int k = 0; k < 4; k++) begin
                raw[k] = 14'($urandom_range(0, 4095));
                filt[k] = 14'($urandom_range(0, 4095));
            end
            hit = f_hit(c, f ? filt[idx(c)] : raw[idx(c)], t);
            wr(ch ? `ADDR_THRESH_TWO : `ADDR_THRESH_ONE, t);
            wr(`ADDR_CONTROL, (16'(f) << 4) | (16'(c) << (ch ? 12 : 8)));
            give_sample();
            step(1);
            check("flags", {14'h0000, alarm_flags_o}, 16'(hit) << ch);
            rd(`ADDR_STATUS);
            check("status", q, 16'(hit) << (8 + ch));
            check("cleared", {14'h0000, alarm_flags_o}, 16'h0000);
        end
        $display("test static done");
        for (int r = 0; r < 4; r++) begin
            ch = r[1];
            wr(ch ? `ADDR_THRESH_TWO : `ADDR_THRESH_ONE, 16'h8040);
            wr(ch ? `ADDR_COUNT_TWO : `ADDR_COUNT_ONE, 16'hFF03);
            wr(`ADDR_CONTROL, 16'h0000);
            wr(`ADDR_CONTROL, ch ? 16'hA000 : 16'h0A00);
            t = 16'($urandom_range(0, 1024));
            for (int j = 0; j < 4; j++) begin
                raw[1] = 14'(t + j * (r[0] ? 16'h0040 : 16'h0041));
                give_sample();
                if (j == 2) check("early", {14'h0000, alarm_flags_o}, 16'h0000);
            end
            step(1);
            check("rate", {14'h0000, alarm_flags_o}, 16'(!r[0]) << ch);
            rd(`ADDR_STATUS);
        end
        $display("test rate done");
        wr(`ADDR_THRESH_ONE, 16'h8010);
        wr(`ADDR_CONTROL, 16'h0104);
        raw[0] = 14'h0020;
        give_sample();
        step(2);
        check("alarm line", {14'h0000, line_oe_o[0], line_o[0]}, 16'h0002);
        drdy_en_i = 1'b1;
        drdy_pol_i = 1'b1;
        drdy_i = 1'b1;
        step(2);
        check("ready line", {14'h0000, line_oe_o[0], line_o[0]}, 16'h0003);
        gpio_out_en_i = 2'b01;
        step(2);
        check("gpio line", {14'h0000, line_oe_o[0], line_o[0]}, 16'h0002);
        gpio_out_en_i = 2'b00;
        drdy_en_i = 1'b0;
        wr(`ADDR_CONTROL, 16'h0107);
        step(1);
        check("line one", {13'h0000, line_oe_o, line_o[1]}, 16'h0005);
        drdy_en_i = 1'b1;
        drdy_sel_i = 1'b1;
        drdy_pol_i = 1'b0;
        step(2);
        check("ready one", {14'h0000, line_oe_o[1], line_o[1]}, 16'h0002);
        gpio_out_en_i = 2'b10;
        gpio_level_i = 2'b11;
        step(2);
        check("gpio one", {14'h0000, line_oe_o[1], line_o[1]}, 16'h0003);
        $display("test lines done");
        results();
    end
endmodule
